// >>> hdl/psc_button.sv
`timescale 1ns/1ps
`default_nettype none
module psc_button #(
   parameter int DEB_CYC = psc_pkg::PSC_DEB_CYC,
   parameter longint HOLD_CYC = psc_pkg::PSC_HOLD_CYC
) (
   input wire logic pclk,       // Clock
   input wire logic presetn,    // Async reset, low
   input wire logic btn_n,      // Raw switch pin, low pressed
   output logic short_press,    // Released before threshold
   output logic long_press      // Threshold reached while held
);
   initial begin
      if (DEB_CYC < 1 || HOLD_CYC < 2) $error("psc_button: bad counts");
   end

   ////////////////////////////////////////////////////////////////
   logic [2:0] sync_q;
   logic stable_q;
   logic [31:0] deb_q;
   logic [39:0] hold_q;
   logic fired_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sync_q <= 3'h7;
      else sync_q <= {sync_q[1:0], btn_n};
   end

   // Debounce: level must stay put for DEB_CYC cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_q <= 1'b0;
         deb_q <= 32'h0;
      end else if ((sync_q[2] == sync_q[1]) && (!sync_q[2] != stable_q)) begin
         if (deb_q >= 32'(DEB_CYC - 1)) begin
            stable_q <= !sync_q[2];
            deb_q <= 32'h0;
         end else begin
            deb_q <= deb_q + 32'h1;
         end
      end else begin
         deb_q <= 32'h0;
      end
   end

   // Press length measured on debounced level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 40'h0;
         fired_q <= 1'b0;
         short_press <= 1'b0;
         long_press <= 1'b0;
      end else begin
         short_press <= 1'b0;
         long_press <= 1'b0;
         if (stable_q) begin
            if (!fired_q && hold_q >= 40'(HOLD_CYC - 1)) begin
               long_press <= 1'b1;
               fired_q <= 1'b1;
            end else if (!fired_q) begin
               hold_q <= hold_q + 40'h1;
            end
         end else begin
            if (hold_q != 40'h0 && !fired_q) short_press <= 1'b1;
            hold_q <= 40'h0;
            fired_q <= 1'b0;
         end
      end
   end
endmodule // psc_button
`default_nettype wire

// >>> hdl/psc_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Short press toggles off/working/sleep states
// - Long press forces soft-off from anywhere
// - States S0, S1, S3, S4, S5; no S2
// - Software commands power state transitions
// - Software soft-off command reaches S5
// - Button, RTC, PCIe wake from all sleeps
// - Modem, keyboard, USB wake only S1/S3
// - LAN/PME wake S5 only when enabled
// - S5 wake enable lets LAN power on
// - One switch serves power and sleep
// - Fans on in S0/S1 only
// - Restore last on/off state after AC loss
// - PME wake needs PME enable
module psc_sleep_ctrl #(
   parameter int DEB_CYC = psc_pkg::PSC_DEB_CYC,
   parameter longint HOLD_CYC = psc_pkg::PSC_HOLD_CYC
) (
   input wire logic pclk,                  // Standby clock
   input wire logic presetn,               // Standby reset, low
   input wire logic psel,                  // APB select
   input wire logic penable,               // APB enable
   input wire logic pwrite,                // APB direction
   input wire logic [11:0] paddr,          // APB byte address
   input wire logic [31:0] pwdata,         // APB write data
   output logic [31:0] prdata,             // APB read data
   output logic pready,                    // APB ready
   output logic pslverr,                   // APB error
   input wire logic pwr_btn_n,             // Front panel switch, low pressed
   input wire logic rtc_alarm,             // RTC alarm, pin
   input wire logic pcie_wake_n,           // PCIe wake pin, low
   input wire logic lan_wake,              // LAN wake, pin
   input wire logic pme_n,                 // PCI PME pin, low
   input wire logic modem_ring,            // Serial modem ring, pin
   input wire logic kbms_act,              // Keyboard/mouse activity, pin
   input wire logic usb_act,               // USB activity, pin
   input wire logic ac_restored,           // Reset came from AC return
   input wire logic last_on_nv,            // Stored last state was on
   output psc_pkg::psc_state_t sys_state,  // Current power state
   output psc_pkg::psc_rails_t rails,      // Power controls
   output logic irq                        // Level interrupt
);
   initial begin
      if (DEB_CYC < 1 || HOLD_CYC < 2) $error("psc_sleep_ctrl: bad counts");
   end

   ////////////////////////////////////////////////////////////////
   // Pin synchronisers, three stages; active-high wake vector
   logic [psc_pkg::PSC_NSRC-1:0] raw_w;
   logic [psc_pkg::PSC_NSRC-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_prev_q;
   assign raw_w = {usb_act, kbms_act, modem_ring, !pme_n, lan_wake, !pcie_wake_n, rtc_alarm, 1'b0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
         lvl_q <= 8'h00;
         lvl_prev_q <= 8'h00;
      end else begin
         s1_q <= raw_w;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
         lvl_prev_q <= lvl_q;
      end
   end

   logic short_press, long_press;
   psc_button #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_btn (
      .pclk(pclk),
      .presetn(presetn),
      .btn_n(pwr_btn_n),
      .short_press(short_press),
      .long_press(long_press)
   );

   ////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] ctrl_q;
   logic [7:0] wstat_q, wmask_q;
   logic wr_en, rd_en, go_cmd;
   logic [2:0] cmd_code;
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   function automatic logic addr_ok(input logic [11:0] a);
      return a == psc_pkg::PSC_OFS_CTRL || a == psc_pkg::PSC_OFS_STATE ||
             a == psc_pkg::PSC_OFS_WSTAT || a == psc_pkg::PSC_OFS_WMASK;
   endfunction

   assign pslverr = psel && penable && !addr_ok(paddr);
   assign go_cmd = wr_en && paddr == psc_pkg::PSC_OFS_CTRL && pwdata[psc_pkg::PSC_CTRL_GO_BIT];
   assign cmd_code = pwdata[psc_pkg::PSC_CTRL_CMD_LSB +: 3];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_q <= psc_pkg::PSC_CTRL_RST;
      else if (wr_en && paddr == psc_pkg::PSC_OFS_CTRL) begin
         ctrl_q <= {21'h0, pwdata[10:8], 8'h00};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wmask_q <= psc_pkg::PSC_WMASK_RST;
      else if (wr_en && paddr == psc_pkg::PSC_OFS_WMASK) wmask_q <= pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////
   // Wake qualification
   psc_pkg::psc_state_t st_q;
   logic s5_wake_en, pme_en;
   logic [7:0] edge_w, qual_w;
   assign s5_wake_en = ctrl_q[psc_pkg::PSC_CTRL_S5WAKE_BIT];
   assign pme_en = ctrl_q[psc_pkg::PSC_CTRL_PMEEN_BIT];
   assign edge_w = lvl_q & ~lvl_prev_q;

   function automatic logic [7:0] wake_allowed(input psc_pkg::psc_state_t s, input logic s5en, input logic pmeen);
      logic [7:0] m;
      m = 8'h00;
      case (s)
         psc_pkg::PSC_S1, psc_pkg::PSC_S3: m = 8'hff;
         psc_pkg::PSC_S4: m = 8'h1f;
         psc_pkg::PSC_S5: m = s5en ? 8'h1f : 8'h07;
         default: m = 8'h00;
      endcase
      if (!pmeen) m[psc_pkg::PSC_W_PME] = 1'b0;
      return m;
   endfunction

   assign qual_w = edge_w & wake_allowed(st_q, s5_wake_en, pme_en);

   ////////////////////////////////////////////////////////////////
   // Power state machine
   logic asleep, wake_now, restore_q;
   assign asleep = st_q != psc_pkg::PSC_S0;
   assign wake_now = (|qual_w) || (short_press && asleep);

   function automatic logic legal_cmd(input logic [2:0] c);
      return c == 3'h0 || c == 3'h1 || c == 3'h3 || c == 3'h4 || c == 3'h5;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= psc_pkg::PSC_S5;
         restore_q <= 1'b1;
      end else begin
         restore_q <= 1'b0;
         if (restore_q) begin
            if (ac_restored && last_on_nv) st_q <= psc_pkg::PSC_S0;
         end else if (long_press) begin
            st_q <= psc_pkg::PSC_S5;
         end else if (wake_now) begin
            st_q <= psc_pkg::PSC_S0;
         end else if (short_press) begin
            st_q <= psc_pkg::PSC_S1;
         end else if (go_cmd && legal_cmd(cmd_code)) begin
            st_q <= psc_pkg::psc_state_t'(cmd_code);
         end
      end
   end
   assign sys_state = st_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rails <= '0;
      else begin
         rails.fan_on <= st_q == psc_pkg::PSC_S0 || st_q == psc_pkg::PSC_S1;
         rails.main_power_on <= st_q == psc_pkg::PSC_S0 || st_q == psc_pkg::PSC_S1;
         rails.cpu_run <= st_q == psc_pkg::PSC_S0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Wake cause status; a new cause wins over a same-cycle clear
   logic [7:0] cause_w, clr_w;
   always_comb begin
      cause_w = qual_w;
      cause_w[psc_pkg::PSC_W_PWRBTN] = short_press && asleep && !long_press;
   end
   assign clr_w = (wr_en && paddr == psc_pkg::PSC_OFS_WSTAT) ? pwdata[7:0] : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wstat_q <= 8'h00;
      else wstat_q <= (wstat_q & ~clr_w) | cause_w;
   end

   assign irq = |(wstat_q & wmask_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) begin
         if (paddr == psc_pkg::PSC_OFS_CTRL) prdata <= ctrl_q;
         else if (paddr == psc_pkg::PSC_OFS_STATE) prdata <= {29'h0, st_q};
         else if (paddr == psc_pkg::PSC_OFS_WSTAT) prdata <= {24'h0, wstat_q};
         else if (paddr == psc_pkg::PSC_OFS_WMASK) prdata <= {24'h0, wmask_q};
         else prdata <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   // A software command only counts when nothing of higher priority moves the state
   logic cmd_free, mask_wr;
   assign cmd_free = !restore_q && !long_press && !wake_now && !short_press;
   assign mask_wr = wr_en && paddr == psc_pkg::PSC_OFS_WMASK;

   sequence s_restore_on;
      restore_q && ac_restored && last_on_nv;
   endsequence

   sequence s_power_up;
      (st_q == psc_pkg::PSC_S0) ##1 rails.cpu_run;
   endsequence

   sequence s_sw_cmd;
      go_cmd && cmd_free && legal_cmd(cmd_code);
   endsequence

   sequence s_wstat_clear;
      (clr_w != 8'h00) && (cause_w == 8'h00);
   endsequence

   property p_long_off;
      @(posedge pclk) disable iff (!presetn)
      long_press |=> st_q == psc_pkg::PSC_S5;
   endproperty
   a_long_off: assert property (p_long_off) else $error("long press not to S5");

   property p_short_wake;
      @(posedge pclk) disable iff (!presetn)
      (short_press && asleep && !long_press && !restore_q) |=> st_q == psc_pkg::PSC_S0;
   endproperty
   a_short_wake: assert property (p_short_wake) else $error("short press did not wake");

   property p_short_sleep;
      @(posedge pclk) disable iff (!presetn)
      (short_press && !asleep && !long_press && !restore_q) |=> st_q == psc_pkg::PSC_S1;
   endproperty
   a_short_sleep: assert property (p_short_sleep) else $error("short press did not sleep");

   property p_no_s2;
      @(posedge pclk) disable iff (!presetn)
      st_q != 3'h2 && st_q != 3'h6 && st_q != 3'h7;
   endproperty
   a_no_s2: assert property (p_no_s2) else $error("illegal power state");

   property p_fan;
      @(posedge pclk) disable iff (!presetn)
      ##1 rails.fan_on == ($past(st_q) == psc_pkg::PSC_S0 || $past(st_q) == psc_pkg::PSC_S1);
   endproperty
   a_fan: assert property (p_fan) else $error("fan state wrong");

   property p_s45_ignore;
      @(posedge pclk) disable iff (!presetn)
      (st_q == psc_pkg::PSC_S4 || st_q == psc_pkg::PSC_S5) |-> qual_w[7:5] == 3'h0;
   endproperty
   a_s45_ignore: assert property (p_s45_ignore) else $error("modem/kb/usb wake in S4/S5");

   property p_s5_lan;
      @(posedge pclk) disable iff (!presetn)
      (st_q == psc_pkg::PSC_S5 && !s5_wake_en) |-> !qual_w[psc_pkg::PSC_W_LAN] && !qual_w[psc_pkg::PSC_W_PME];
   endproperty
   a_s5_lan: assert property (p_s5_lan) else $error("LAN wake in S5 while disabled");

   property p_pme;
      @(posedge pclk) disable iff (!presetn)
      !pme_en |-> !qual_w[psc_pkg::PSC_W_PME];
   endproperty
   a_pme: assert property (p_pme) else $error("PME wake while disabled");

   property p_cause;
      @(posedge pclk) disable iff (!presetn)
      ((|qual_w) && !long_press) |=> ((wstat_q & $past(qual_w)) == $past(qual_w)) && st_q == psc_pkg::PSC_S0;
   endproperty
   a_cause: assert property (p_cause) else $error("wake cause not latched");

   property p_restore_on;
      @(posedge pclk) disable iff (!presetn)
      s_restore_on |=> s_power_up;
   endproperty
   a_restore_on: assert property (p_restore_on) else $error("stored on state not restored");

   property p_restore_off;
      @(posedge pclk) disable iff (!presetn)
      (restore_q && !(ac_restored && last_on_nv)) |=> st_q == psc_pkg::PSC_S5;
   endproperty
   a_restore_off: assert property (p_restore_off) else $error("powered up without stored on state");

   property p_sw_cmd;
      @(posedge pclk) disable iff (!presetn)
      s_sw_cmd |=> st_q == $past(cmd_code);
   endproperty
   a_sw_cmd: assert property (p_sw_cmd) else $error("software state command not taken");

   property p_bad_cmd;
      @(posedge pclk) disable iff (!presetn)
      (go_cmd && cmd_free && !legal_cmd(cmd_code)) |=> $stable(st_q);
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("unsupported state code taken");

   property p_s0_ignore;
      @(posedge pclk) disable iff (!presetn)
      !asleep |-> qual_w == 8'h00;
   endproperty
   a_s0_ignore: assert property (p_s0_ignore) else $error("wake taken while working");

   property p_w1c;
      @(posedge pclk) disable iff (!presetn)
      s_wstat_clear |=> (wstat_q & $past(clr_w)) == 8'h00;
   endproperty
   a_w1c: assert property (p_w1c) else $error("wake cause not cleared");

   property p_irq_up;
      @(posedge pclk) disable iff (!presetn)
      ((cause_w & wmask_q) != 8'h00 && !mask_wr) |=> irq;
   endproperty
   a_irq_up: assert property (p_irq_up) else $error("unmasked wake cause without interrupt");

   property p_fan_off;
      @(posedge pclk) disable iff (!presetn)
      (st_q == psc_pkg::PSC_S3 || st_q == psc_pkg::PSC_S4 || st_q == psc_pkg::PSC_S5) |=>
         !rails.fan_on && !rails.main_power_on;
   endproperty
   a_fan_off: assert property (p_fan_off) else $error("fan or main power on in deep sleep");

   property p_sleep_cpu;
      @(posedge pclk) disable iff (!presetn)
      asleep |=> !rails.cpu_run;
   endproperty
   a_sleep_cpu: assert property (p_sleep_cpu) else $error("processor running while asleep");

   property p_cpu_main;
      @(posedge pclk) disable iff (!presetn)
      rails.cpu_run |-> rails.main_power_on;
   endproperty
   a_cpu_main: assert property (p_cpu_main) else $error("processor running without main power");

   property p_one_press;
      @(posedge pclk) disable iff (!presetn)
      !(short_press && long_press);
   endproperty
   a_one_press: assert property (p_one_press) else $error("short and long press together");
endmodule // psc_sleep_ctrl
`default_nettype wire

// >>> pkg/psc_pkg.sv
package psc_pkg;
   // System power states; S2 is deliberately absent
   typedef enum logic [2:0] {
      PSC_S0 = 3'h0,
      PSC_S1 = 3'h1,
      PSC_S3 = 3'h3,
      PSC_S4 = 3'h4,
      PSC_S5 = 3'h5
   } psc_state_t;

   // Register byte offsets
   localparam logic [11:0] PSC_OFS_CTRL = 12'h000;
   localparam logic [11:0] PSC_OFS_STATE = 12'h004;
   localparam logic [11:0] PSC_OFS_WSTAT = 12'h008;
   localparam logic [11:0] PSC_OFS_WMASK = 12'h00c;

   // Control register fields
   localparam int PSC_CTRL_CMD_LSB = 0;
   localparam int PSC_CTRL_GO_BIT = 4;
   localparam int PSC_CTRL_S5WAKE_BIT = 8;
   localparam int PSC_CTRL_PMEEN_BIT = 9;
   localparam int PSC_CTRL_LASTON_BIT = 10;
   localparam logic [31:0] PSC_CTRL_RST = 32'h0000_0000;

   // Wake source bit positions in status, mask and source vectors
   localparam int PSC_NSRC = 8;
   localparam int PSC_W_PWRBTN = 0;
   localparam int PSC_W_RTC = 1;
   localparam int PSC_W_PCIE = 2;
   localparam int PSC_W_LAN = 3;
   localparam int PSC_W_PME = 4;
   localparam int PSC_W_MODEM = 5;
   localparam int PSC_W_KBMS = 6;
   localparam int PSC_W_USB = 7;
   localparam logic [7:0] PSC_WMASK_RST = 8'h00;

   // Timing
   localparam int PSC_CLK_HZ = 50_000_000;
   localparam int PSC_HOLD_S = 4;
   localparam longint PSC_HOLD_CYC = longint'(PSC_HOLD_S) * PSC_CLK_HZ;
   localparam int PSC_DEB_US = 10;
   localparam int PSC_DEB_CYC = PSC_DEB_US * (PSC_CLK_HZ / 1_000_000);

   typedef struct packed {
      logic fan_on;
      logic main_power_on;
      logic cpu_run;
   } psc_rails_t;
endpackage

// >>> verification/psc_sleep_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module psc_sleep_ctrl_bench;
   localparam int HOLD = 50;
   localparam logic [11:0] A_CTRL = psc_pkg::PSC_OFS_CTRL;
   localparam logic [11:0] A_ST = psc_pkg::PSC_OFS_STATE;
   localparam logic [11:0] A_WS = psc_pkg::PSC_OFS_WSTAT;
   localparam logic [11:0] A_WM = psc_pkg::PSC_OFS_WMASK;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ac_restored, last_on_nv, err, hit;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] req;
   logic pwr_btn_n, rtc_alarm, pcie_wake_n, lan_wake, pme_n, modem_ring, kbms_act, usb_act;
   psc_pkg::psc_state_t sys_state;
   psc_pkg::psc_rails_t rails;
   psc_pkg::psc_state_t sleeps[4] = '{psc_pkg::PSC_S1, psc_pkg::PSC_S3, psc_pkg::PSC_S4, psc_pkg::PSC_S5};
   logic [31:0] cfgs[3] = '{32'h0000_0000, 32'h0000_0100, 32'h0000_0300};
   int miscompares, total_checks;

   psc_sleep_ctrl #(.DEB_CYC(3), .HOLD_CYC(HOLD)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwr_btn_n(pwr_btn_n), .rtc_alarm(rtc_alarm), .pcie_wake_n(pcie_wake_n),
      .lan_wake(lan_wake), .pme_n(pme_n), .modem_ring(modem_ring), .kbms_act(kbms_act), .usb_act(usb_act),
      .ac_restored(ac_restored), .last_on_nv(last_on_nv), .sys_state(sys_state), .rails(rails), .irq(irq));
   psc_wake_model u_src (.req(req), .pwr_btn_n(pwr_btn_n), .rtc_alarm(rtc_alarm), .pcie_wake_n(pcie_wake_n),
      .lan_wake(lan_wake), .pme_n(pme_n), .modem_ring(modem_ring), .kbms_act(kbms_act), .usb_act(usb_act));

   ////////////////////////////////////////
   task automatic finish_test();
      $display("total_checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask

   task automatic wait_st(input psc_pkg::psc_state_t e);
      int n;
      n = 0;
      while (sys_state !== e && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk("sys_state", 32'(e), 32'(sys_state));
      if (n >= 300) finish_test();
   endtask

   task automatic pulse(input int s, input int cyc);
      @(posedge pclk);
      req[s] <= 1'b1;
      repeat (cyc) @(posedge pclk);
      req[s] <= 1'b0;
   endtask

   function automatic logic allowed(input psc_pkg::psc_state_t st, input int s, input logic [31:0] cfg);
      logic s5ok;
      s5ok = (st != psc_pkg::PSC_S5) || cfg[psc_pkg::PSC_CTRL_S5WAKE_BIT];
      if (s <= psc_pkg::PSC_W_PCIE) return 1'b1;
      if (s == psc_pkg::PSC_W_LAN) return s5ok;
      if (s == psc_pkg::PSC_W_PME) return s5ok && cfg[psc_pkg::PSC_CTRL_PMEEN_BIT];
      return (st == psc_pkg::PSC_S1) || (st == psc_pkg::PSC_S3);
   endfunction

   ////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      repeat (100000) @(posedge pclk);
      miscompares++;
      finish_test();
   end

   initial begin
      {presetn, psel, penable, pwrite, ac_restored, last_on_nv} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      req = 8'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("rails", 32'h0, 32'(rails));
      rdchk("state", A_ST, 32'h5);
      rdchk("ctrl", A_CTRL, psc_pkg::PSC_CTRL_RST);
      rdchk("wmask", A_WM, 32'(psc_pkg::PSC_WMASK_RST));
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("pslverr", 32'h1, 32'(err));
      chk("unmapped", 32'h0, rd);
      pulse(psc_pkg::PSC_W_PWRBTN, 10);
      wait_st(psc_pkg::PSC_S0);
      repeat (3) @(posedge pclk);
      chk("rails", 32'h7, 32'(rails));
      apb(1'b1, A_WS, 32'h0000_00ff);
      pulse(psc_pkg::PSC_W_PWRBTN, 10);
      wait_st(psc_pkg::PSC_S1);
      repeat (3) @(posedge pclk);
      chk("rails", 32'h6, 32'(rails));
      apb(1'b1, A_WM, 32'h0000_0040);
      pulse(psc_pkg::PSC_W_KBMS, 6);
      wait_st(psc_pkg::PSC_S0);
      rdchk("wstat", A_WS, 32'h40);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, A_WM, 32'h0000_0000);
      // The mask write lands at the edge the task returns on
      @(posedge pclk);
      chk("irq", 32'h0, 32'(irq));
      apb(1'b1, A_WM, 32'h0000_0040);
      apb(1'b1, A_WS, 32'h0000_0040);
      rdchk("wstat", A_WS, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      // Working state must swallow wake events without latching them
      pulse(psc_pkg::PSC_W_RTC, 6);
      repeat (20) @(posedge pclk);
      rdchk("wstat", A_WS, 32'h0);
      apb(1'b1, A_CTRL, 32'h0000_0700);
      rdchk("ctrl", A_CTRL, 32'h0000_0700);
      apb(1'b1, A_CTRL, 32'h0000_0012);
      rdchk("state", A_ST, 32'h0);
      apb(1'b1, A_CTRL, 32'h0000_0013);
      repeat (3) @(posedge pclk);
      chk("rails", 32'h0, 32'(rails));
      foreach (cfgs[c]) begin
         foreach (sleeps[i]) begin
            for (int s = 1; s < psc_pkg::PSC_NSRC; s++) begin
               hit = allowed(sleeps[i], s, cfgs[c]);
               apb(1'b1, A_CTRL, cfgs[c] | 32'h10 | 32'(sleeps[i]));
               pulse(s, 6);
               if (hit) wait_st(psc_pkg::PSC_S0);
               else repeat (20) @(posedge pclk);
               rdchk("state", A_ST, hit ? 32'h0 : 32'(sleeps[i]));
               rdchk("wstat", A_WS, hit ? (32'h1 << s) : 32'h0);
               apb(1'b1, A_WS, 32'h0000_00ff);
            end
         end
      end
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, A_CTRL, k ? 32'h13 : 32'h10);
         @(posedge pclk);
         req[psc_pkg::PSC_W_PWRBTN] <= 1'b1;
         repeat (HOLD + 20) @(posedge pclk);
         chk("held", 32'h5, 32'(sys_state));
         req[psc_pkg::PSC_W_PWRBTN] <= 1'b0;
         repeat (30) @(posedge pclk);
         chk("released", 32'h5, 32'(sys_state));
      end
      apb(1'b1, A_CTRL, 32'h0000_0010);
      apb(1'b1, A_CTRL, 32'h0000_0015);
      rdchk("state", A_ST, 32'h5);
      // Second reset imitates AC return with the stored state on
      ac_restored <= 1'b1;
      last_on_nv <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      wait_st(psc_pkg::PSC_S0);
      repeat (3) @(posedge pclk);
      chk("rails", 32'h7, 32'(rails));
      finish_test();
   end
endmodule // psc_sleep_ctrl_bench
`default_nettype wire

// >>> verification/psc_wake_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_wake_model (
   input wire logic [7:0] req, // One request bit per wake source
   output logic pwr_btn_n,     // Switch pin, low pressed
   output logic rtc_alarm,     // Alarm pin
   output logic pcie_wake_n,   // Wake pin, low active
   output logic lan_wake,      // LAN wake pin
   output logic pme_n,         // PME pin, low active
   output logic modem_ring,    // Ring indicator
   output logic kbms_act,      // Keyboard/mouse activity
   output logic usb_act        // USB activity
);
   // Low-active lines are driven as the inverse of their req bit, so a released line reads high, never the old level
   assign pwr_btn_n = ~req[psc_pkg::PSC_W_PWRBTN];
   assign rtc_alarm = req[psc_pkg::PSC_W_RTC];
   assign pcie_wake_n = ~req[psc_pkg::PSC_W_PCIE];
   assign lan_wake = req[psc_pkg::PSC_W_LAN];
   assign pme_n = ~req[psc_pkg::PSC_W_PME];
   assign modem_ring = req[psc_pkg::PSC_W_MODEM];
   assign kbms_act = req[psc_pkg::PSC_W_KBMS];
   assign usb_act = req[psc_pkg::PSC_W_USB];
endmodule // psc_wake_model
`default_nettype wire
